// file: rtl/diag_ident_pkg.sv
// Shared constants and carrier types for the diagnostic, verify, readback and
// identification register bank.
// Assumes a 20 MHz system clock and a 4 MHz internal timing tick derived from it.
package diag_ident_pkg;

    // ========================================================================
    // Serial frame layout
    // ========================================================================
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int HDR_W = 8;
    localparam int FRAME_W = 24;
    localparam int WRITE_BIT = 2;
    localparam int ADDR_LSB = 3;

    // ========================================================================
    // Register addresses
    // ========================================================================
    localparam logic [ADDR_W-1:0] ADDR_CHECK_REQUEST = 5'h09;
    localparam logic [ADDR_W-1:0] ADDR_DRIVER_STATUS = 5'h0a;
    localparam logic [ADDR_W-1:0] ADDR_WATCHDOG_COUNT = 5'h0b;
    localparam logic [ADDR_W-1:0] ADDR_CHECK_OUTCOME = 5'h0e;
    localparam logic [ADDR_W-1:0] ADDR_SCRATCH = 5'h0f;
    localparam logic [ADDR_W-1:0] ADDR_IDENTITY = 5'h10;

    // ========================================================================
    // Field positions and reset values
    // ========================================================================
    localparam int DRV_STATUS_LSB = 8;
    localparam int OC_COUNT_W = 8;
    localparam int LOGIC_LEVEL_BIT = 14;
    localparam int REVISION_LSB = 10;
    localparam int REVISION_W = 4;
    localparam int CHIP_CODE_W = 8;
    localparam int SENSE_OPEN_BIT = 0;
    localparam int PRESCALE_W = 2;
    localparam int WDOG_COUNT_W = 16;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int TIMING_CLK_HZ = 4_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WDOG_UNIT_NS = 4000;
    localparam int TICK_CYCLES = SYS_CLK_HZ / TIMING_CLK_HZ;
    localparam int WDOG_UNIT_CYCLES = WDOG_UNIT_NS / CLK_PERIOD_NS;

    // ========================================================================
    // Carrier types
    // ========================================================================
    typedef struct packed {
        logic bridge_latched_on;
        logic reverse_latched_on;
        logic phase_w_latched_on;
        logic phase_v_latched_on;
        logic phase_u_latched_on;
    } driver_status_s;

    typedef struct packed {
        logic check_pos_supply_mon;
        logic check_neg_supply_mon;
        logic check_watchdog_mon;
        logic check_pos_overcurrent_mon;
        logic check_neg_overcurrent_mon;
        logic check_temp_warning;
        logic check_pump_undervoltage;
    } check_request_s;

endpackage

// file: rtl/diag_verify_ident_regs.sv
// Diagnostic, verify, readback and identification registers behind a serial port.
// Assumes a mode-0 serial master, 24-bit frames, and same-clock status inputs.
//
// Operation
// - Five read-only latched driver enable bits, bridge in bit twelve.
// - Eight-bit overcurrent count n brackets duration between p*n and p*(n+1).
// - Prescale p picked by two-bit setting; timing clock is 4 MHz.
// - Sixteen-bit watchdog elapsed count, one unit per 4 microseconds.
// - Both diagnostic words are read-only and reset to zero.
// - Scratch register at address fifteen returns written value; resets zero.
// - Identity at sixteen: read-only chip code and major/minor silicon revision.
// - Identity bit fourteen shows the selected internal logic voltage level.
// - Outcome register bit zero flags open current-sense comparator input.
// - Check request word has separate bits for each monitor check.
`timescale 1ns/1ps

module diag_verify_ident_regs #(
    parameter logic [7:0] CHIP_CODE = 8'h5a,    // Arbitrary value.
    parameter logic [3:0] SILICON_REVISION = 4'h0  // Arbitrary value.
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Serial port pins
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdi_in,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_out,
    // Driver and monitor status, same clock
    input diag_ident_pkg::driver_status_s driver_status_in,
    input wire logic [diag_ident_pkg::PRESCALE_W-1:0] overcurrent_prescale_in,
    input wire logic watchdog_restart_in,
    input wire logic sense_open_flag_in,
    // Asynchronous levels from pins
    input wire logic overcurrent_active_in,
    input wire logic logic_level_flag_in,
    // Check requests toward the monitors
    output diag_ident_pkg::check_request_s check_request_out
);

    localparam int CNT_W = $clog2(diag_ident_pkg::FRAME_W + 1);
    localparam int SYNC_N = 5;
    localparam logic [SYNC_N-1:0] SYNC_RESET = 5'h02;  // Chip select idles high.
    localparam logic [CNT_W-1:0] HDR_COUNT = CNT_W'(diag_ident_pkg::HDR_W);
    localparam logic [CNT_W-1:0] FRAME_COUNT = CNT_W'(diag_ident_pkg::FRAME_W);
    localparam int TICK_W = $clog2(diag_ident_pkg::TICK_CYCLES);
    localparam int UNIT_W = $clog2(diag_ident_pkg::WDOG_UNIT_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(diag_ident_pkg::TICK_CYCLES - 1);
    localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(diag_ident_pkg::WDOG_UNIT_CYCLES - 1);
    localparam int PRE_W = 3;

    // ========================================================================
    // Reset release
    // ========================================================================
    logic rst_meta_q;
    logic rst_sync_q;

    // Release is synchronous so no flop sees reset drop near its edge.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    logic [SYNC_N-1:0] pins_raw;
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    logic oc_active_s;
    logic level_s;

    assign pins_raw = {spi_sclk_in, logic_level_flag_in, overcurrent_active_in,
                       spi_cs_n_in, spi_sdi_in};

    // Two flops per pin; only the second stage feeds any logic.
    always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    assign sclk_s = sync2_q[4];
    assign level_s = sync2_q[3];
    assign oc_active_s = sync2_q[2];
    assign cs_n_s = sync2_q[1];
    assign sdi_s = sync2_q[0];

    // ========================================================================
    // Serial frame engine
    // ========================================================================
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [CNT_W-1:0] bit_cnt_d;
    logic [diag_ident_pkg::FRAME_W-1:0] rx_q;
    logic [diag_ident_pkg::FRAME_W-1:0] rx_d;
    logic [diag_ident_pkg::DATA_W-1:0] tx_q;
    logic [diag_ident_pkg::DATA_W-1:0] tx_d;
    logic sdo_q;
    logic sdo_d;
    logic sdo_oe_q;
    logic sdo_oe_d;
    logic wr_pulse;
    logic [diag_ident_pkg::DATA_W-1:0] rd_data;
    logic rise;
    logic fall;

    assign rise = sclk_s && !sclk_prev_q;
    assign fall = !sclk_s && sclk_prev_q;

    // Sample on rising clock, shift out on falling clock. Read data is fetched
    // after the header so the host sees it during the same frame.
    always_comb begin
        sclk_prev_d = sclk_s;
        bit_cnt_d = bit_cnt_q;
        rx_d = rx_q;
        tx_d = tx_q;
        sdo_d = sdo_q;
        sdo_oe_d = !cs_n_s;
        wr_pulse = 1'b0;
        if (cs_n_s) begin
            bit_cnt_d = '0;
            sdo_d = 1'b0;
        end else if (rise && bit_cnt_q < FRAME_COUNT) begin
            rx_d = {rx_q[diag_ident_pkg::FRAME_W-2:0], sdi_s};
            bit_cnt_d = bit_cnt_q + CNT_W'(1);
            if (bit_cnt_q == HDR_COUNT - CNT_W'(1)) begin
                tx_d = rd_data;
            end
            if (bit_cnt_q == FRAME_COUNT - CNT_W'(1)) begin
                // A short frame never reaches here, so it writes nothing.
                wr_pulse = rx_q[diag_ident_pkg::DATA_W-1+diag_ident_pkg::WRITE_BIT];
            end
        end else if (fall && bit_cnt_q >= HDR_COUNT) begin
            sdo_d = tx_q[diag_ident_pkg::DATA_W-1];
            tx_d = {tx_q[diag_ident_pkg::DATA_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sclk_prev_q <= 1'b0;
            bit_cnt_q <= '0;
            rx_q <= '0;
            tx_q <= '0;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_prev_d;
            bit_cnt_q <= bit_cnt_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
        end
    end

    // Address and data of the frame being committed, as the final bit arrives.
    logic [diag_ident_pkg::ADDR_W-1:0] commit_addr;
    logic [diag_ident_pkg::ADDR_W-1:0] read_addr;

    assign commit_addr = rx_q[diag_ident_pkg::FRAME_W-2 -: diag_ident_pkg::ADDR_W];
    // At the eighth rise the seven header bits so far hold the whole address.
    assign read_addr = rx_q[diag_ident_pkg::ADDR_LSB+diag_ident_pkg::ADDR_W-2 -:
                            diag_ident_pkg::ADDR_W];

    // ========================================================================
    // Timing counters
    // ========================================================================
    logic [TICK_W-1:0] tick_div_q;
    logic [TICK_W-1:0] tick_div_d;
    logic [PRE_W-1:0] pre_cnt_q;
    logic [PRE_W-1:0] pre_cnt_d;
    logic [PRE_W-1:0] pre_last;
    logic [diag_ident_pkg::OC_COUNT_W-1:0] oc_count_q;
    logic [diag_ident_pkg::OC_COUNT_W-1:0] oc_count_d;
    logic oc_prev_q;
    logic oc_prev_d;
    logic [UNIT_W-1:0] unit_div_q;
    logic [UNIT_W-1:0] unit_div_d;
    logic [diag_ident_pkg::WDOG_COUNT_W-1:0] wdog_count_q;
    logic [diag_ident_pkg::WDOG_COUNT_W-1:0] wdog_count_d;
    logic tick;

    assign tick = (tick_div_q == TICK_LAST);
    assign pre_last = PRE_W'((1 << overcurrent_prescale_in) - 1);

    // Overcurrent count holds whole prescaled periods; it restarts on each new
    // event and freezes afterwards so the host can still read the duration.
    always_comb begin
        tick_div_d = tick ? '0 : tick_div_q + TICK_W'(1);
        oc_prev_d = oc_active_s;
        pre_cnt_d = pre_cnt_q;
        oc_count_d = oc_count_q;
        if (oc_active_s && !oc_prev_q) begin
            pre_cnt_d = '0;
            oc_count_d = '0;
        end else if (oc_active_s && tick) begin
            if (pre_cnt_q >= pre_last) begin
                pre_cnt_d = '0;
                if (oc_count_q != '1) begin
                    oc_count_d = oc_count_q + diag_ident_pkg::OC_COUNT_W'(1);
                end
            end else begin
                pre_cnt_d = pre_cnt_q + PRE_W'(1);
            end
        end
        // Watchdog count saturates rather than wraps, so a stalled host shows full.
        unit_div_d = unit_div_q;
        wdog_count_d = wdog_count_q;
        if (watchdog_restart_in) begin
            unit_div_d = '0;
            wdog_count_d = '0;
        end else if (unit_div_q == UNIT_LAST) begin
            unit_div_d = '0;
            if (wdog_count_q != '1) begin
                wdog_count_d = wdog_count_q + diag_ident_pkg::WDOG_COUNT_W'(1);
            end
        end else begin
            unit_div_d = unit_div_q + UNIT_W'(1);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tick_div_q <= '0;
            pre_cnt_q <= '0;
            oc_count_q <= '0;
            oc_prev_q <= 1'b0;
            unit_div_q <= '0;
            wdog_count_q <= '0;
        end else begin
            tick_div_q <= tick_div_d;
            pre_cnt_q <= pre_cnt_d;
            oc_count_q <= oc_count_d;
            oc_prev_q <= oc_prev_d;
            unit_div_q <= unit_div_d;
            wdog_count_q <= wdog_count_d;
        end
    end

    // ========================================================================
    // Writable registers and captured status
    // ========================================================================
    logic [diag_ident_pkg::DATA_W-1:0] scratch_q;
    logic [diag_ident_pkg::DATA_W-1:0] scratch_d;
    diag_ident_pkg::check_request_s check_req_q;
    diag_ident_pkg::check_request_s check_req_d;
    logic level_q;
    logic level_d;
    logic level_taken_q;
    logic level_taken_d;
    logic [1:0] level_wait_q;
    logic [1:0] level_wait_d;
    logic [diag_ident_pkg::DATA_W-1:0] wdata;

    assign wdata = rx_q[diag_ident_pkg::DATA_W-1:0];

    // The logic level strap is caught once after reset release, then held.
    always_comb begin
        scratch_d = scratch_q;
        check_req_d = check_req_q;
        level_d = level_taken_q ? level_q : level_s;
        // Wait out the synchroniser's reset value before taking the strap.
        level_wait_d = {level_wait_q[0], 1'b1};
        level_taken_d = level_wait_q[1];
        if (wr_pulse && commit_addr == diag_ident_pkg::ADDR_SCRATCH) begin
            scratch_d = {wdata[diag_ident_pkg::DATA_W-2:0], sdi_s};
        end
        if (wr_pulse && commit_addr == diag_ident_pkg::ADDR_CHECK_REQUEST) begin
            // Only the seven request bits store; the rest are dropped.
            check_req_d = {wdata[13], wdata[12], wdata[11],
                           wdata[2], wdata[1], wdata[0], sdi_s};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            scratch_q <= diag_ident_pkg::REG_RESET;
            check_req_q <= '0;
            level_q <= 1'b0;
            level_taken_q <= 1'b0;
            level_wait_q <= 2'h0;
        end else begin
            scratch_q <= scratch_d;
            check_req_q <= check_req_d;
            level_q <= level_d;
            level_taken_q <= level_taken_d;
            level_wait_q <= level_wait_d;
        end
    end

    // ========================================================================
    // Read multiplexer
    // ========================================================================
    // Read-only words ignore writes simply by having no write path.
    always_comb begin
        rd_data = '0;
        unique case (read_addr)
            diag_ident_pkg::ADDR_CHECK_REQUEST: begin
                rd_data = {1'b0, check_req_q[6:4], 8'h00, check_req_q[3:0]};
            end
            diag_ident_pkg::ADDR_DRIVER_STATUS: begin
                rd_data[diag_ident_pkg::DRV_STATUS_LSB +: 5] = driver_status_in;
                rd_data[diag_ident_pkg::OC_COUNT_W-1:0] = oc_count_q;
            end
            diag_ident_pkg::ADDR_WATCHDOG_COUNT: begin
                rd_data = wdog_count_q;
            end
            diag_ident_pkg::ADDR_CHECK_OUTCOME: begin
                rd_data[diag_ident_pkg::SENSE_OPEN_BIT] = sense_open_flag_in;
            end
            diag_ident_pkg::ADDR_SCRATCH: begin
                rd_data = scratch_q;
            end
            diag_ident_pkg::ADDR_IDENTITY: begin
                rd_data[diag_ident_pkg::CHIP_CODE_W-1:0] = CHIP_CODE;
                rd_data[diag_ident_pkg::REVISION_LSB +: diag_ident_pkg::REVISION_W] =
                    SILICON_REVISION;
                rd_data[diag_ident_pkg::LOGIC_LEVEL_BIT] = level_q;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign spi_sdo_out = sdo_q;
    assign spi_sdo_oe_out = sdo_oe_q;
    assign check_request_out = check_req_q;

    // Host duties bound the timing this bank reports; nothing here enforces them.
    // The watchdog count lets the host see its margin to the timeout.

endmodule // diag_verify_ident_regs

// file: tb/diag_chk.sv
// Checker for the serial port pins and the check request outputs of the bank.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps

// ============
// Checker
module diag_chk (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Serial pins
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdo_out,
    input wire logic spi_sdo_oe_out,
    // Check requests
    input diag_ident_pkg::check_request_s check_request_out
);
    // One clock domain, so clock and reset are given once for all properties.
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Select and serial clock levels held long enough to pass the synchroniser.
    sequence cs_idle_s;
        spi_cs_n_in [*6];
    endsequence
    sequence cs_busy_s;
        !spi_cs_n_in [*5];
    endsequence
    sequence sclk_high_s;
        spi_sclk_in [*5];
    endsequence

    AST_REQ_RESET: assert property ($rose(rst_n_in) |-> check_request_out == '0 && !spi_sdo_oe_out)
        else $error("Outputs not cleared at reset release.");
    AST_REQ_COMMIT: assert property ($changed(check_request_out) |-> !$past(spi_cs_n_in, 3))
        else $error("Check requests changed outside a frame.");
    AST_REQ_IDLE: assert property (cs_idle_s |-> $stable(check_request_out))
        else $error("Check requests moved while deselected.");
    AST_SDO_IDLE: assert property (!spi_sdo_oe_out |-> !spi_sdo_out)
        else $error("Serial output high while not enabled.");
    AST_OE_RISE: assert property ($fell(spi_cs_n_in) |-> ##[1:4] spi_sdo_oe_out)
        else $error("Output enable late after select.");
    AST_OE_DROP: assert property ($rose(spi_cs_n_in) |-> ##[1:4] !spi_sdo_oe_out)
        else $error("Output enable late to drop after deselect.");
    AST_OE_HOLD: assert property (cs_busy_s |-> spi_sdo_oe_out)
        else $error("Output enable low inside a frame.");
    AST_SDO_HOLD: assert property (sclk_high_s |-> $stable(spi_sdo_out))
        else $error("Serial output changed while serial clock high.");
endmodule // diag_chk

bind diag_verify_ident_regs diag_chk u_chk (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .spi_sclk_in(spi_sclk_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_sdo_out(spi_sdo_out), .spi_sdo_oe_out(spi_sdo_oe_out),
    .check_request_out(check_request_out));

// file: tb/spi_host_model.sv
// Serial host model: mode 0 frames of up to 24 bits, most significant bit first.
// Assumes the 20 MHz bank clock; each serial clock phase lasts at least five cycles.
`timescale 1ns/1ps

// ============
// Host model
module spi_host_model (
    // Clock
    input wire logic sys_clk_in,
    // Serial pins
    output logic spi_sclk_out,
    output logic spi_cs_n_out,
    output logic spi_sdi_out,
    input wire logic spi_sdo_in,
    input wire logic spi_sdo_oe_in
);
    logic rbit_q;

    // Idle levels; the serial clock stands low outside frames.
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_sdi_out = 1'b0;
        rbit_q = 1'b0;
    end

    // Phase switch-off timing stays with the host; no frame here carries it.
    // One frame; fewer than 24 bits gives a cut-short frame that must write nothing.
    task automatic xfer(input logic [23:0] frame, input int nbits, output logic [15:0] rdata);
        rdata = 16'h0000;
        @(posedge sys_clk_in);
        spi_cs_n_out <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            repeat (5) @(posedge sys_clk_in);
            spi_sdi_out <= frame[23-i];
            repeat (5) @(posedge sys_clk_in);
            spi_sclk_out <= 1'b1;
            // A released output is read as the inverse of its last level, never a lucky copy.
            rbit_q = spi_sdo_oe_in ? spi_sdo_in : ~rbit_q;
            if (i >= 8) begin
                rdata[23-i] = rbit_q;
            end
            repeat (5) @(posedge sys_clk_in);
            spi_sclk_out <= 1'b0;
        end
        repeat (5) @(posedge sys_clk_in);
        spi_cs_n_out <= 1'b1;
        // The data line toggles for six cycles after each frame so a stale level is never trusted.
        repeat (6) begin
            @(posedge sys_clk_in);
            spi_sdi_out <= ~spi_sdi_out;
        end
    endtask
endmodule // spi_host_model

// file: tb/diag_verify_ident_regs_tb_top.sv
// Self-checking bench for the diagnostic and identification register bank.
// Assumes the serial host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

// ============
// Bench top
module diag_verify_ident_regs_tb_top;
    localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value.
    localparam logic [3:0] ID_REV = 4'h9; // Arbitrary value.
    logic sys_clk_in, rst_n_in, sclk, cs_n, sdi, sdo, sdo_oe;
    logic restart, sense_open, oc_active, level;
    logic [1:0] prescale;
    logic [15:0] v;
    diag_ident_pkg::driver_status_s drv;
    diag_ident_pkg::check_request_s req;
    int mismatches, checks, cycles;
    int pos [7] = '{14, 13, 12, 3, 2, 1, 0};

    diag_verify_ident_regs #(.CHIP_CODE(ID_CODE), .SILICON_REVISION(ID_REV)) DUT (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .spi_sclk_in(sclk),
        .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
        .driver_status_in(drv), .overcurrent_prescale_in(prescale),
        .watchdog_restart_in(restart), .sense_open_flag_in(sense_open),
        .overcurrent_active_in(oc_active), .logic_level_flag_in(level),
        .check_request_out(req));

    spi_host_model host (.sys_clk_in(sys_clk_in), .spi_sclk_out(sclk), .spi_cs_n_out(cs_n),
        .spi_sdi_out(sdi), .spi_sdo_in(sdo), .spi_sdo_oe_in(sdo_oe));

    // Clock at 20 MHz.
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // A hang is cut short well above the expected run of about 16000 cycles.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            conclude();
        end
    end

    // ============
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A window check, since tick phase against the event edge is free.
    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.xfer({a, 1'b0, 2'b00, 16'h0000}, 24, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] r;
        host.xfer({a, 1'b1, 2'b00, d}, 24, r);
    endtask

    task automatic do_reset();
        rst_n_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge sys_clk_in);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ============
    // Tests
    initial begin
        rst_n_in = 1'b0;
        drv = '0;
        prescale = 2'b00;
        restart = 1'b1;
        sense_open = 1'b0;
        oc_active = 1'b0;
        level = 1'b1;
        do_reset();
        // Reset values, with the watchdog count held clear by a restart level.
        rd(diag_ident_pkg::ADDR_DRIVER_STATUS, diag_ident_pkg::REG_RESET);
        rd(diag_ident_pkg::ADDR_WATCHDOG_COUNT, diag_ident_pkg::REG_RESET);
        rd(diag_ident_pkg::ADDR_CHECK_OUTCOME, diag_ident_pkg::REG_RESET);
        rd(diag_ident_pkg::ADDR_SCRATCH, diag_ident_pkg::REG_RESET);
        rd(diag_ident_pkg::ADDR_CHECK_REQUEST, diag_ident_pkg::REG_RESET);
        restart <= 1'b0;
        $display("test reset values done");
        // Identity is fixed and ignores writes.
        rd(diag_ident_pkg::ADDR_IDENTITY, {2'b01, ID_REV, 2'b00, ID_CODE});
        wr(diag_ident_pkg::ADDR_IDENTITY, 16'hffff);
        rd(diag_ident_pkg::ADDR_IDENTITY, {2'b01, ID_REV, 2'b00, ID_CODE});
        $display("test identity done");
        // Scratch loopback, a cut-short frame and an unmapped address.
        wr(diag_ident_pkg::ADDR_SCRATCH, 16'ha5c3);
        rd(diag_ident_pkg::ADDR_SCRATCH, 16'ha5c3);
        wr(diag_ident_pkg::ADDR_SCRATCH, 16'hffff);
        host.xfer({diag_ident_pkg::ADDR_SCRATCH, 1'b1, 2'b00, 16'h1234}, 20, v);
        rd(diag_ident_pkg::ADDR_SCRATCH, 16'hffff);
        rd(5'h1f, 16'h0000);
        $display("test scratch done");
        // Check request bits, all at once and then one at a time.
        wr(diag_ident_pkg::ADDR_CHECK_REQUEST, 16'hffff);
        rd(diag_ident_pkg::ADDR_CHECK_REQUEST, 16'h700f);
        chk({9'h000, req}, 16'h007f);
        for (int i = 0; i < 7; i++) begin
            wr(diag_ident_pkg::ADDR_CHECK_REQUEST, 16'h0001 << pos[i]);
            chk({9'h000, req}, 16'h0040 >> i);
        end
        $display("test check requests done");
        // Driver status and sense-open flag, read-only.
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk_in);
            drv <= diag_ident_pkg::driver_status_s'(i == 0 ? 5'h15 : 5'h0a);
            sense_open <= (i == 0);
            rd(diag_ident_pkg::ADDR_DRIVER_STATUS, i == 0 ? 16'h1500 : 16'h0a00);
            wr(diag_ident_pkg::ADDR_DRIVER_STATUS, 16'hffff);
            rd(diag_ident_pkg::ADDR_DRIVER_STATUS, i == 0 ? 16'h1500 : 16'h0a00);
            rd(diag_ident_pkg::ADDR_CHECK_OUTCOME, i == 0 ? 16'h0001 : 16'h0000);
        end
        $display("test status done");
        // Overcurrent lasting just over six counts at every prescale setting.
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk_in);
            prescale <= s[1:0];
            oc_active <= 1'b1;
            repeat (30 * (1 << s) + 2) @(posedge sys_clk_in);
            oc_active <= 1'b0;
            repeat (5) @(posedge sys_clk_in);
            host.xfer({diag_ident_pkg::ADDR_DRIVER_STATUS, 1'b0, 2'b00, 16'h0000}, 24, v);
            chk_rng({8'h00, v[7:0]}, 16'h0006, 16'h0007);
        end
        $display("test overcurrent timer done");
        // Watchdog count some 21 units after a restart pulse.
        @(posedge sys_clk_in);
        restart <= 1'b1;
        @(posedge sys_clk_in);
        restart <= 1'b0;
        repeat (1600) @(posedge sys_clk_in);
        host.xfer({diag_ident_pkg::ADDR_WATCHDOG_COUNT, 1'b0, 2'b00, 16'h0000}, 24, v);
        chk_rng(v, 16'h0014, 16'h0016);
        $display("test watchdog done");
        // Second reset with the logic level strap turned low.
        level <= 1'b0;
        do_reset();
        rd(diag_ident_pkg::ADDR_SCRATCH, diag_ident_pkg::REG_RESET);
        rd(diag_ident_pkg::ADDR_IDENTITY, {2'b00, ID_REV, 2'b00, ID_CODE});
        $display("test second reset done");
        conclude();
    end
endmodule // diag_verify_ident_regs_tb_top
